// *** hdl/gil_pkg.sv ***
package gil_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_PIN_MAP = 8'h1b;
   localparam logic [7:0] IDX_FIFO_IRQ_EN = 8'h1e;
   localparam logic [7:0] IDX_HOLD_CTRL = 8'h21;
   localparam logic [7:0] IDX_EVT_STATUS = 8'h30;
   localparam logic [7:0] IDX_EVT_MASK = 8'h31;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int WM_EN_BIT = 7;
   localparam int CLR_INT_BIT = 7;
   localparam int CLR_OFFSET_BIT = 6;
   localparam int LATCH_STATUS_BIT = 4;
   localparam int PIN1_FIFO_MAP_BIT = 2;
   localparam int PIN2_FIFO_MAP_BIT = 5;
   localparam int EVT_WM_BIT = 0;
   localparam int EVT_PIN1_BIT = 1;
   localparam int EVT_PIN2_BIT = 2;
   localparam int EVT_W = 3;
   localparam logic [7:0] FIFO_IRQ_EN_RST = 8'h88;
   localparam logic [7:0] HOLD_CTRL_RST = 8'h00;
   localparam logic [7:0] PIN_MAP_RST = 8'h00;
   localparam logic [3:0] MODE_LATCH_A = 4'h7;
   localparam logic [3:0] MODE_LATCH_B = 4'hf;
   localparam logic [3:0] MODE_NONL_A = 4'h0;
   localparam logic [3:0] MODE_NONL_B = 4'h8;

   // ----------------------------------------------------------------
   // hold times in microseconds, codes 1..6 then 9..14
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned HOLD_US [12] = '{250000, 500000, 1000000, 2000000, 4000000,
      8000000, 250, 500, 1000, 12500, 25000, 50000};
   localparam int unsigned HOLD_CYC_DEF [12] = '{HOLD_US[0] * CLK_MHZ,
      HOLD_US[1] * CLK_MHZ, HOLD_US[2] * CLK_MHZ, HOLD_US[3] * CLK_MHZ,
      HOLD_US[4] * CLK_MHZ, HOLD_US[5] * CLK_MHZ, HOLD_US[6] * CLK_MHZ,
      HOLD_US[7] * CLK_MHZ, HOLD_US[8] * CLK_MHZ, HOLD_US[9] * CLK_MHZ,
      HOLD_US[10] * CLK_MHZ, HOLD_US[11] * CLK_MHZ};

   typedef enum logic [1:0] {
      HOLD_NONLATCHED = 2'b00,
      HOLD_TEMPORARY = 2'b01,
      HOLD_LATCHED = 2'b11
   } gil_hold_kind_t;

endpackage

// *** hdl/gil_hold_timer.sv ***
module gil_hold_timer (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // control
   input wire gil_pkg::gil_hold_kind_t holdKind,
   input wire logic [31:0] holdCycles,
   input wire logic clearCmd,
   // condition in, held interrupt out
   input wire logic cond,
   output logic irq
);

   logic [31:0] count;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
         count <= 32'h0;
      end else begin
         unique case (holdKind)
            gil_pkg::HOLD_NONLATCHED: begin
               irq <= cond; // R05 R11
               count <= 32'h0;
            end
            gil_pkg::HOLD_LATCHED: begin
               // a new assertion beats a clear in the same cycle
               irq <= cond | (irq & ~clearCmd); // R08 R10
               count <= 32'h0;
            end
            gil_pkg::HOLD_TEMPORARY: begin
               if (cond) begin
                  count <= holdCycles; // R06 R07
                  irq <= 1'b1;
               // hold counts down from the last cycle the condition was seen, so
               // the pin stays up for the full count after the condition goes away
               end else if (clearCmd || count == 32'h0) begin
                  count <= 32'h0; // R10
                  irq <= 1'b0;
               end else begin
                  count <= count - 32'h1;
                  irq <= 1'b1;
               end
            end
            default: begin
               irq <= 1'b0;
               count <= 32'h0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   follow_cond_a: assert property (@(posedge clk) disable iff (!resetn) // R11
      holdKind == gil_pkg::HOLD_NONLATCHED && $stable(holdKind) |-> irq == $past(cond))
      else $error("non-latched output does not follow its condition");

   latch_hold_a: assert property (@(posedge clk) disable iff (!resetn) // R10
      holdKind == gil_pkg::HOLD_LATCHED && irq && !clearCmd ##1
      holdKind == gil_pkg::HOLD_LATCHED |-> irq)
      else $error("latched interrupt dropped without a clear");

   temp_reload_a: assert property (@(posedge clk) disable iff (!resetn) // R06
      holdKind == gil_pkg::HOLD_TEMPORARY && cond |=> count == $past(holdCycles) && irq)
      else $error("hold counter not loaded with the hold time");

   temp_expire_a: assert property (@(posedge clk) disable iff (!resetn) // R10
      holdKind == gil_pkg::HOLD_TEMPORARY && !cond && count == 32'h0 |=> !irq)
      else $error("temporary interrupt outlives its hold time");

   temp_held_c: cover property (@(posedge clk) disable iff (!resetn)
      holdKind == gil_pkg::HOLD_TEMPORARY && irq && !cond ##1 irq ##1 !irq);

endmodule

// *** hdl/gil_interrupt_latch_control.sv ***
// What this block does
// R01 - the fifo watermark interrupt is produced only while its enable bit is one.
// R02 - software writes zero to every reserved bit of the enable and hold control registers.
// R03 - writing one to the clear-interrupt command resets the held state of every interrupt.
// R04 - writing one to the clear-offset command resets the fast and slow offset results.
// R05 - hold codes 0000b and 1000b select non-latched outputs, and the field resets to zero.
// R06 - codes 0001b to 0110b hold an interrupt for 250 ms, 500 ms, 1 s, 2 s, 4 s and 8 s.
// R07 - codes 1001b to 1110b hold an interrupt for 250 us, 500 us, 1 ms, 12.5 ms, 25 ms, 50 ms.
// R08 - codes 0111b and 1111b latch asserted interrupts.
// R09 - the fifo interrupt reaches each gyro pin only when that pin's map bit is one.
// R10 - a latched interrupt stays until cleared, a temporary one drops after its hold time.
// R11 - a non-latched output follows its condition and drops as soon as it goes away.
//
// Register access over AHB-Lite is this design's own decision.
module gil_interrupt_latch_control #(
   parameter int unsigned HOLD_CYC [12] = gil_pkg::HOLD_CYC_DEF
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // condition from the fifo
   input wire logic fifoWatermarkLevel,
   // interrupt pins and commands to the engines
   output logic gyro_irq_pin_first,
   output logic gyro_irq_pin_second,
   output logic intStatusClear,
   output logic fast_offset_comp_clear,
   output logic slow_offset_comp_clear,
   output logic irqOut
);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] fifoIrqEnable;
   logic [3:0] holdMode;
   logic latchStatus;
   logic pin1FifoMap;
   logic pin2FifoMap;
   logic [gil_pkg::EVT_W-1:0] evtStatus;
   logic [gil_pkg::EVT_W-1:0] evtMask;

   // ----------------------------------------------------------------
   // bus address and data phase
   // ----------------------------------------------------------------
   logic accept;
   logic wrPend;
   logic rdWait;
   logic [7:0] phaseIdx;
   logic addrOk;
   logic wrStrobe;
   logic [7:0] wd;
   logic [31:0] next_rdata;

   assign accept = hsel & htrans[1] & hready;
   assign wrStrobe = wrPend;
   assign wd = hwdata[7:0];
   // word aligned addresses only; low bits must be zero
   assign addrOk = (haddr[1:0] == 2'b00) && (haddr[31:10] == 22'h0);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wrPend <= 1'b0;
         rdWait <= 1'b0;
         phaseIdx <= 8'h0;
         hreadyout <= 1'b1;
      end else begin
         wrPend <= accept & hwrite;
         if (accept) begin
            phaseIdx <= addrOk ? haddr[9:2] : 8'hff;
         end
         // one wait state on reads so a preceding write is visible
         if (accept && !hwrite) begin
            rdWait <= 1'b1;
            hreadyout <= 1'b0;
         end else begin
            rdWait <= 1'b0;
            hreadyout <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   always_comb begin
      next_rdata = 32'h0;
      unique case (phaseIdx)
         gil_pkg::IDX_FIFO_IRQ_EN: next_rdata = {24'h0, fifoIrqEnable};
         gil_pkg::IDX_HOLD_CTRL: next_rdata = {27'h0, latchStatus, holdMode};
         gil_pkg::IDX_PIN_MAP: begin
            next_rdata[gil_pkg::PIN1_FIFO_MAP_BIT] = pin1FifoMap;
            next_rdata[gil_pkg::PIN2_FIFO_MAP_BIT] = pin2FifoMap;
         end
         gil_pkg::IDX_EVT_STATUS: next_rdata = {29'h0, evtStatus};
         gil_pkg::IDX_EVT_MASK: next_rdata = {29'h0, evtMask};
         default: next_rdata = 32'h0;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hrdata <= 32'h0;
      end else if (rdWait) begin
         hrdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fifoIrqEnable <= gil_pkg::FIFO_IRQ_EN_RST;
      end else if (wrStrobe && phaseIdx == gil_pkg::IDX_FIFO_IRQ_EN) begin
         fifoIrqEnable <= wd;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         holdMode <= gil_pkg::HOLD_CTRL_RST[3:0]; // R05
         latchStatus <= gil_pkg::HOLD_CTRL_RST[gil_pkg::LATCH_STATUS_BIT];
      end else if (wrStrobe && phaseIdx == gil_pkg::IDX_HOLD_CTRL) begin
         holdMode <= wd[3:0];
         latchStatus <= wd[gil_pkg::LATCH_STATUS_BIT];
      end
   end

   // command bits are not stored; they fire one-cycle pulses
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         intStatusClear <= 1'b0;
         fast_offset_comp_clear <= 1'b0;
         slow_offset_comp_clear <= 1'b0;
      end else begin
         intStatusClear <= wrStrobe && phaseIdx == gil_pkg::IDX_HOLD_CTRL
            && wd[gil_pkg::CLR_INT_BIT]; // R03
         fast_offset_comp_clear <= wrStrobe && phaseIdx == gil_pkg::IDX_HOLD_CTRL
            && wd[gil_pkg::CLR_OFFSET_BIT]; // R04
         slow_offset_comp_clear <= wrStrobe && phaseIdx == gil_pkg::IDX_HOLD_CTRL
            && wd[gil_pkg::CLR_OFFSET_BIT]; // R04
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin1FifoMap <= gil_pkg::PIN_MAP_RST[gil_pkg::PIN1_FIFO_MAP_BIT];
         pin2FifoMap <= gil_pkg::PIN_MAP_RST[gil_pkg::PIN2_FIFO_MAP_BIT];
      end else if (wrStrobe && phaseIdx == gil_pkg::IDX_PIN_MAP) begin
         pin1FifoMap <= wd[gil_pkg::PIN1_FIFO_MAP_BIT];
         pin2FifoMap <= wd[gil_pkg::PIN2_FIFO_MAP_BIT];
      end
   end

   // ----------------------------------------------------------------
   // hold mode decode
   // ----------------------------------------------------------------
   gil_pkg::gil_hold_kind_t holdKind;
   logic [31:0] holdCycles;

   always_comb begin
      holdKind = gil_pkg::HOLD_TEMPORARY;
      holdCycles = 32'h1;
      unique case (holdMode)
         gil_pkg::MODE_NONL_A, gil_pkg::MODE_NONL_B: begin
            holdKind = gil_pkg::HOLD_NONLATCHED; // R05
         end
         gil_pkg::MODE_LATCH_A, gil_pkg::MODE_LATCH_B: begin
            holdKind = gil_pkg::HOLD_LATCHED; // R08
         end
         4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
            holdCycles = 32'(HOLD_CYC[3'(holdMode[2:0] - 3'h1)]); // R06
         end
         default: begin
            holdCycles = 32'(HOLD_CYC[4'(holdMode[2:0]) + 4'h5]); // R07
         end
      endcase
   end

   // ----------------------------------------------------------------
   // fifo interrupt, pin mapping and holding
   // ----------------------------------------------------------------
   logic fifoIrq;
   logic pin1Cond;
   logic pin2Cond;

   assign fifoIrq = fifoWatermarkLevel & fifoIrqEnable[gil_pkg::WM_EN_BIT]; // R01
   assign pin1Cond = fifoIrq & pin1FifoMap; // R09
   assign pin2Cond = fifoIrq & pin2FifoMap; // R09

   gil_hold_timer u_hold_first (
      .clk(clk),
      .resetn(resetn),
      .holdKind(holdKind),
      .holdCycles(holdCycles),
      .clearCmd(intStatusClear),
      .cond(pin1Cond),
      .irq(gyro_irq_pin_first)
   );

   gil_hold_timer u_hold_second (
      .clk(clk),
      .resetn(resetn),
      .holdKind(holdKind),
      .holdCycles(holdCycles),
      .clearCmd(intStatusClear),
      .cond(pin2Cond),
      .irq(gyro_irq_pin_second)
   );

   // ----------------------------------------------------------------
   // event status, mask and interrupt line
   // ----------------------------------------------------------------
   logic fifoIrqQ;
   logic pin1Q;
   logic pin2Q;
   logic [gil_pkg::EVT_W-1:0] evtSet;
   logic [gil_pkg::EVT_W-1:0] evtClr;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fifoIrqQ <= 1'b0;
         pin1Q <= 1'b0;
         pin2Q <= 1'b0;
      end else begin
         fifoIrqQ <= fifoIrq;
         pin1Q <= gyro_irq_pin_first;
         pin2Q <= gyro_irq_pin_second;
      end
   end

   always_comb begin
      evtSet = '0;
      evtSet[gil_pkg::EVT_WM_BIT] = fifoIrq & ~fifoIrqQ;
      evtSet[gil_pkg::EVT_PIN1_BIT] = gyro_irq_pin_first & ~pin1Q;
      evtSet[gil_pkg::EVT_PIN2_BIT] = gyro_irq_pin_second & ~pin2Q;
   end

   assign evtClr = (wrStrobe && phaseIdx == gil_pkg::IDX_EVT_STATUS) ?
      wd[gil_pkg::EVT_W-1:0] : '0;

   // set wins over a same-cycle clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         evtStatus <= '0;
      end else begin
         evtStatus <= (evtStatus & ~evtClr) | evtSet;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         evtMask <= '0;
      end else if (wrStrobe && phaseIdx == gil_pkg::IDX_EVT_MASK) begin
         evtMask <= wd[gil_pkg::EVT_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irqOut <= 1'b0;
      end else begin
         irqOut <= |(evtStatus & evtMask);
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   wm_suppress_a: assert property (@(posedge clk) disable iff (!resetn) // R01
      !fifoIrqEnable[gil_pkg::WM_EN_BIT] && !fifoIrqQ |=> !evtStatus[gil_pkg::EVT_WM_BIT]
      || $past(evtStatus[gil_pkg::EVT_WM_BIT]))
      else $error("watermark event raised while disabled");

   clear_pulse_a: assert property (@(posedge clk) disable iff (!resetn) // R03
      wrStrobe && phaseIdx == gil_pkg::IDX_HOLD_CTRL && wd[gil_pkg::CLR_INT_BIT]
      |=> intStatusClear ##1 !intStatusClear)
      else $error("clear command did not pulse for one cycle");

   offset_pulse_a: assert property (@(posedge clk) disable iff (!resetn) // R04
      fast_offset_comp_clear == slow_offset_comp_clear && (fast_offset_comp_clear ==
      $past(wrStrobe && phaseIdx == gil_pkg::IDX_HOLD_CTRL && wd[gil_pkg::CLR_OFFSET_BIT])))
      else $error("offset clear pulse mismatch");

   long_hold_a: assert property (@(posedge clk) disable iff (!resetn) // R06
      holdMode == 4'h6 |-> holdCycles == HOLD_CYC[5] && holdKind == gil_pkg::HOLD_TEMPORARY)
      else $error("8 s hold count wrong");

   short_hold_a: assert property (@(posedge clk) disable iff (!resetn) // R07
      holdMode == 4'h9 |-> holdCycles == HOLD_CYC[6] && holdKind == gil_pkg::HOLD_TEMPORARY)
      else $error("250 us hold count wrong");

   latch_mode_a: assert property (@(posedge clk) disable iff (!resetn) // R08
      holdMode[2:0] == 3'h7 |-> holdKind == gil_pkg::HOLD_LATCHED)
      else $error("latch code not decoded as latched");

   nonlatch_mode_a: assert property (@(posedge clk) disable iff (!resetn) // R05
      holdMode[2:0] == 3'h0 |-> holdKind == gil_pkg::HOLD_NONLATCHED)
      else $error("non-latched code decoded wrongly");

   pin_map_a: assert property (@(posedge clk) disable iff (!resetn) // R09
      !pin1FifoMap && holdKind == gil_pkg::HOLD_NONLATCHED ##1
      holdKind == gil_pkg::HOLD_NONLATCHED |-> !gyro_irq_pin_first)
      else $error("unmapped fifo interrupt reached the first pin");

   read_wait_a: assert property (@(posedge clk) disable iff (!resetn)
      accept && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read data phase is not exactly one wait state");

   latch_path_c: cover property (@(posedge clk) disable iff (!resetn)
      holdKind == gil_pkg::HOLD_LATCHED && gyro_irq_pin_first ##[1:20] intStatusClear);
   irq_out_c: cover property (@(posedge clk) disable iff (!resetn) $rose(irqOut));
   nonlatch_c: cover property (@(posedge clk) disable iff (!resetn)
      holdKind == gil_pkg::HOLD_NONLATCHED && $fell(gyro_irq_pin_second));

endmodule

// *** sim/tb.sv ***
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // short hold counts keep every temporary mode inside the run
   // ----------------------------------------------------------------
   localparam int unsigned HC [12] = '{10, 20, 30, 40, 50, 60, 3, 4, 5, 6, 7, 8};
   localparam int LIM = 100;
   localparam logic [7:0] MAP = gil_pkg::IDX_PIN_MAP;
   localparam logic [7:0] FEN = gil_pkg::IDX_FIFO_IRQ_EN;
   localparam logic [7:0] HOLD = gil_pkg::IDX_HOLD_CTRL;
   localparam logic [7:0] STAT = gil_pkg::IDX_EVT_STATUS;
   localparam logic [7:0] MASK = gil_pkg::IDX_EVT_MASK;

   typedef struct {
      logic [3:0] mode;
      int unsigned hold;
   } gil_row_t;

   // latched modes saturate the sampling window at LIM
   gil_row_t rows [16] = '{'{4'h0, 0}, '{4'h1, HC[0]}, '{4'h2, HC[1]}, '{4'h3, HC[2]},
      '{4'h4, HC[3]}, '{4'h5, HC[4]}, '{4'h6, HC[5]}, '{4'h7, LIM},
      '{4'h8, 0}, '{4'h9, HC[6]}, '{4'ha, HC[7]}, '{4'hb, HC[8]},
      '{4'hc, HC[9]}, '{4'hd, HC[10]}, '{4'he, HC[11]}, '{4'hf, LIM}};

   logic clk;
   logic resetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic fifoWatermarkLevel;
   logic gyro_irq_pin_first;
   logic gyro_irq_pin_second;
   logic intStatusClear;
   logic fast_offset_comp_clear;
   logic slow_offset_comp_clear;
   logic irqOut;
   int errors;
   int checked;
   int clrPulses;
   int offPulses;
   int c1;
   int c2;
   int b;
   logic [31:0] rdata;

   gil_interrupt_latch_control #(
      .HOLD_CYC(HC)
   ) u_gil_interrupt_latch_control (
      .clk(clk),
      .resetn(resetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .fifoWatermarkLevel(fifoWatermarkLevel),
      .gyro_irq_pin_first(gyro_irq_pin_first),
      .gyro_irq_pin_second(gyro_irq_pin_second),
      .intStatusClear(intStatusClear),
      .fast_offset_comp_clear(fast_offset_comp_clear),
      .slow_offset_comp_clear(slow_offset_comp_clear),
      .irqOut(irqOut)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // check and report
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // command pulses are counted per cycle, so a stretched pulse shows up
   always @(posedge clk) begin
      if (intStatusClear === 1'b1) clrPulses++;
      if (fast_offset_comp_clear === 1'b1) offPulses++;
      check(32'(fast_offset_comp_clear), 32'(slow_offset_comp_clear));
   end

   // ----------------------------------------------------------------
   // ahb-lite master
   // ----------------------------------------------------------------
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         errors++;
         $display("mismatch at %0t: bus wait ran out", $time);
         final_report();
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'h2;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rdata = hrdata;
      check(32'(hresp), 32'h0);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rd(input logic [7:0] idx);
      bus(1'b0, idx, 32'h0);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // raise the watermark for hi cycles, then count high pin cycles after it falls
   task automatic measure(input int hi);
      fifoWatermarkLevel <= 1'b1;
      idle(hi);
      fifoWatermarkLevel <= 1'b0;
      c1 = 0;
      c2 = 0;
      for (int i = 0; i < LIM; i++) begin
         @(posedge clk);
         #1;
         if (gyro_irq_pin_first === 1'b1) c1++;
         if (gyro_irq_pin_second === 1'b1) c2++;
      end
      @(posedge clk);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      errors = 0;
      checked = 0;
      clrPulses = 0;
      offPulses = 0;
      resetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      fifoWatermarkLevel = 1'b0;
      idle(20);
      resetn <= 1'b1;
      @(posedge clk);
      wr(FEN, 32'h80);
      wr(MAP, 32'h24);
      foreach (rows[i]) begin
         wr(HOLD, {28'h0, rows[i].mode});
         measure(3);
         check(32'(c1), rows[i].hold);
         check(32'(c2), rows[i].hold);
         b = clrPulses;
         wr(HOLD, {24'h0, 4'h8, rows[i].mode});
         idle(2);
         check(32'(gyro_irq_pin_first), 32'h0);
         check(32'(clrPulses - b), 32'h1);
      end
      // command bits are not stored, latch status bit is
      b = offPulses;
      wr(HOLD, 32'hd7);
      rd(HOLD);
      check(rdata, 32'h17);
      check(32'(offPulses - b), 32'h1);
      // clear drops a temporary hold long before its count runs out
      wr(HOLD, 32'h06);
      fifoWatermarkLevel <= 1'b1;
      idle(3);
      fifoWatermarkLevel <= 1'b0;
      idle(5);
      check(32'(gyro_irq_pin_first), 32'h1);
      wr(HOLD, 32'h86);
      idle(2);
      check(32'(gyro_irq_pin_first), 32'h0);
      // non-latched pin follows the level
      wr(HOLD, 32'h00);
      fifoWatermarkLevel <= 1'b1;
      idle(3);
      check(32'(gyro_irq_pin_first), 32'h1);
      fifoWatermarkLevel <= 1'b0;
      idle(2);
      check(32'(gyro_irq_pin_first), 32'h0);
      // watermark disabled: nothing even in latched mode
      wr(FEN, 32'h00);
      wr(HOLD, 32'h07);
      wr(STAT, 32'h07);
      measure(3);
      check(32'(c1 + c2), 32'h0);
      rd(STAT);
      check(rdata, 32'h0);
      // interrupt raised, cleared, then masked; pin2 left unmapped
      wr(FEN, 32'h80);
      wr(HOLD, 32'h00);
      wr(MAP, 32'h04);
      wr(MASK, 32'h01);
      measure(2);
      check(32'(c2), 32'h0);
      check(32'(irqOut), 32'h1);
      rd(STAT);
      check(rdata, 32'h3);
      wr(STAT, 32'h03);
      idle(2);
      check(32'(irqOut), 32'h0);
      wr(MASK, 32'h00);
      measure(2);
      check(32'(irqOut), 32'h0);
      rd(STAT);
      check(rdata, 32'h3);
      // unmapped place reads zero
      wr(8'h20, 32'hff);
      rd(8'h20);
      check(rdata, 32'h0);
      // second reset in mid-run restores the enable, hold, map and mask registers
      resetn <= 1'b0;
      idle(3);
      check(32'(gyro_irq_pin_first), 32'h0);
      resetn <= 1'b1;
      @(posedge clk);
      rd(FEN);
      check(rdata, 32'h88);
      rd(HOLD);
      check(rdata, 32'h0);
      rd(MAP);
      check(rdata, 32'h0);
      rd(MASK);
      check(rdata, 32'h0);
      final_report();
   end
endmodule
